// >>> cbu_pkg.sv
// package of constants and types for the conditional branch unit, plus its condition evaluator
`timescale 1ns/100ps
`default_nettype none
package cbu_pkg;
	// ****************************************
	// encoding
	// ****************************************
	localparam logic [5:0] CBU_OPC_REG = 6'h27;
	localparam logic [5:0] CBU_OPC_IMM = 6'h2F;
	localparam logic [3:0] CBU_COND_EQ = 4'h0;
	localparam logic [3:0] CBU_COND_GE = 4'h5;
	localparam logic [3:0] CBU_COND_GT = 4'h4;
	localparam logic [31:0] CBU_SEQ_STEP = 32'h0000_0004;
	localparam logic [31:0] CBU_ZERO = 32'h0000_0000;
	localparam int CBU_SIGN_BIT = 31;
	localparam int CBU_LIT_SIGN = 15;
	// ****************************************
	// latencies in core cycles
	// ****************************************
	localparam logic [3:0] CBU_LAT_NOT_TAKEN = 4'h1;
	localparam logic [3:0] CBU_LAT_PRED_HIT = 4'h1;
	localparam logic [3:0] CBU_LAT_TAKEN_SLOT = 4'h2;
	localparam logic [3:0] CBU_LAT_TAKEN_NOSLOT = 4'h3;
	localparam logic [3:0] CBU_LAT_MISPRED = 4'h3;
	// deep pipeline flush costs seven to nine; the middle figure is used
	localparam logic [3:0] CBU_LAT_MISPRED_DEEP = 4'h8;
	localparam int CBU_FOOTPRINT_DEEP = 2;
	localparam logic [3:0] CBU_CNT_LAST = 4'h1;
	localparam logic [3:0] CBU_CNT_IDLE = 4'h0;

	// instruction word, most significant field first
	typedef struct packed {
		logic [5:0] opcode;
		logic delay;
		logic [3:0] cond;
		logic [4:0] src_sel;
		logic [15:0] literal;
	} cbu_instr_t;

	typedef struct packed {
		logic taken;
		logic slot;
		logic [31:0] target;
	} cbu_result_t;

	typedef enum logic [2:0] {
		CBU_IDLE = 3'b001,
		CBU_EXEC = 3'b010,
		CBU_SLOT = 3'b100
	} cbu_state_t;
endpackage : cbu_pkg

// condition test of the compared source against zero
module cbu_cond_eval
	import cbu_pkg::*;
(
	input wire logic [3:0] cond_i,
	input wire logic is_imm_i,
	input wire logic [31:0] value_i,
	output logic legal_o,
	output logic take_o
);
	logic is_zero;
	logic is_neg;

	assign is_zero = (value_i == CBU_ZERO);
	assign is_neg = value_i[CBU_SIGN_BIT];

	always_comb begin
		legal_o = 1'b1;
		take_o = 1'b0;
		unique case (cond_i)
			CBU_COND_EQ: begin
				legal_o = is_imm_i;
				take_o = is_zero;
			end
			CBU_COND_GE: take_o = !is_neg;
			CBU_COND_GT: take_o = !is_neg && !is_zero;
			default: legal_o = 1'b0;
		endcase
	end
endmodule : cbu_cond_eval
`default_nettype wire

// >>> cbu_branch_unit.sv
// conditional branch unit: decode, target, latency and interrupt deferral
//
// Function
// - equal immediate branch taken only when compared source is exactly zero
// - greater-or-equal branches taken when compared source is signed non-negative
// - greater-than register branch taken only when compared source is strictly positive
// - immediate target is pc plus extended literal; not taken advances pc by four
// - register target is pc plus offset source; only pc changes
// - taken with delay flag lets the following instruction complete first
// - taken without delay flag squashes the following instruction
// - delay-suffixed variants encode the delay flag as one, plain as zero
// - register form latency one not taken, two with slot, three without
// - immediate form one cycle not taken or predicted right, two with slot
// - immediate form three cycles taken without slot or on mispredict
// - deep pipeline mispredict of immediate form costs seven to nine cycles
// - sixteen-bit literal is sign extended to thirty-two bits by default
// - directly after the upper-half prefix its formed value replaces the extension
// - interrupts and hardware breaks wait until a delay-slot branch and slot finish
`timescale 1ns/100ps
`default_nettype none
module cbu_branch_unit
	import cbu_pkg::*;
#(
	parameter int FOOTPRINT_TUNING_PARAM = 0
) (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic issue_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] pc_i,
	input wire logic [31:0] compared_source_i,
	input wire logic [31:0] offset_source_i,
	input wire logic prefix_valid_i,
	input wire logic [15:0] prefix_hi_i,
	input wire logic pred_valid_i,
	input wire logic pred_taken_i,
	input wire logic slot_done_i,
	input wire logic irq_req_i,
	input wire logic brk_req_i,
	output logic busy_o,
	output logic done_o,
	output logic taken_o,
	output logic slot_o,
	output logic squash_next_o,
	output logic [31:0] next_pc_o,
	output logic defer_o,
	output logic irq_take_o,
	output logic brk_take_o
);
	// ****************************************
	// decode
	// ****************************************
	cbu_instr_t ins;
	logic is_imm;
	logic is_reg;
	logic legal;
	logic cond_take;
	logic start;
	logic [31:0] disp;
	logic [31:0] target;
	logic [3:0] lat;
	cbu_result_t res_d;
	cbu_result_t res_q;
	cbu_state_t state_q;
	logic [3:0] cnt_q;
	logic busy_q;
	logic done_q;
	logic defer_q;
	logic irq_take_q;
	logic brk_take_q;
	logic squash_q;

	assign ins = cbu_instr_t'(instr_i);
	assign is_imm = (ins.opcode == CBU_OPC_IMM);
	assign is_reg = (ins.opcode == CBU_OPC_REG);

	cbu_cond_eval u_cond (
		.cond_i(ins.cond),
		.is_imm_i(is_imm),
		.value_i(compared_source_i),
		.legal_o(legal),
		.take_o(cond_take)
	);

	// a new branch is accepted only while idle
	assign start = issue_i && (state_q == CBU_IDLE) && legal && (is_imm || is_reg);

	always_comb begin
		disp = {{16{ins.literal[CBU_LIT_SIGN]}}, ins.literal};
		if (prefix_valid_i) begin
			disp = {prefix_hi_i, ins.literal};
		end
		if (is_reg) begin
			disp = offset_source_i;
		end
	end

	assign target = cond_take ? pc_i + disp : pc_i + CBU_SEQ_STEP;

	always_comb begin
		res_d.taken = cond_take;
		res_d.slot = ins.delay;
		res_d.target = target;
	end

	// ****************************************
	// latency
	// ****************************************
	always_comb begin
		if (!cond_take) begin
			lat = CBU_LAT_NOT_TAKEN;
		end else if (ins.delay) begin
			lat = CBU_LAT_TAKEN_SLOT;
		end else begin
			lat = CBU_LAT_TAKEN_NOSLOT;
		end
		if (is_imm && pred_valid_i && (pred_taken_i == cond_take)) begin
			lat = CBU_LAT_PRED_HIT;
		end
		if (is_imm && pred_valid_i && (pred_taken_i != cond_take)) begin
			lat = CBU_LAT_MISPRED;
			if (FOOTPRINT_TUNING_PARAM == CBU_FOOTPRINT_DEEP) begin
				lat = CBU_LAT_MISPRED_DEEP;
			end
		end
	end

	// ****************************************
	// sequencing
	// ****************************************
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_q <= CBU_IDLE;
			cnt_q <= CBU_CNT_IDLE;
		end else begin
			unique case (state_q)
				CBU_IDLE: begin
					if (start) begin
						state_q <= CBU_EXEC;
						cnt_q <= lat;
					end
				end
				CBU_EXEC: begin
					cnt_q <= cnt_q - CBU_CNT_LAST;
					if (cnt_q == CBU_CNT_LAST) begin
						state_q <= res_q.slot ? CBU_SLOT : CBU_IDLE;
					end
				end
				CBU_SLOT: begin
					if (slot_done_i) begin
						state_q <= CBU_IDLE;
					end
				end
				default: state_q <= CBU_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= (state_q == CBU_EXEC) && (cnt_q == CBU_CNT_LAST);
			if (start) begin
				busy_q <= 1'b1;
			end else if ((state_q == CBU_EXEC) && (cnt_q == CBU_CNT_LAST)) begin
				busy_q <= 1'b0;
			end
		end
	end

	// result is captured at issue and held until the next branch
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			res_q <= '0;
			squash_q <= 1'b0;
		end else if (start) begin
			res_q <= res_d;
			// taken with no slot means the fetched successor is dropped
			squash_q <= cond_take && !ins.delay;
		end
	end

	// ****************************************
	// interrupt and break deferral
	// ****************************************
	// hold off from issue until the slot instruction retires
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			defer_q <= 1'b0;
		end else if (start && ins.delay) begin
			defer_q <= 1'b1;
		end else if ((state_q == CBU_SLOT) && slot_done_i) begin
			defer_q <= 1'b0;
		end
	end

	// requests pass only when nothing is deferred
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			irq_take_q <= 1'b0;
			brk_take_q <= 1'b0;
		end else begin
			irq_take_q <= irq_req_i && !defer_q && !(start && ins.delay);
			brk_take_q <= brk_req_i && !defer_q && !(start && ins.delay);
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
	assign taken_o = res_q.taken;
	assign slot_o = res_q.slot;
	assign squash_next_o = squash_q;
	assign next_pc_o = res_q.target;
	assign defer_o = defer_q;
	assign irq_take_o = irq_take_q;
	assign brk_take_o = brk_take_q;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	a_eq_zero_take: assert property (start && is_imm && ins.cond == CBU_COND_EQ |=>
		taken_o == ($past(compared_source_i) == CBU_ZERO)) else $error("equal test wrong");
	a_ge_sign_take: assert property (start && ins.cond == CBU_COND_GE |=>
		taken_o == !$past(compared_source_i[CBU_SIGN_BIT])) else $error("ge test wrong");
	a_gt_pos_take: assert property (start && ins.cond == CBU_COND_GT |=>
		taken_o == ($signed($past(compared_source_i)) > 0)) else $error("gt test wrong");
	a_imm_target_ext: assert property (start && is_imm && cond_take && !prefix_valid_i |=>
		next_pc_o == $past(pc_i) + {{16{$past(instr_i[15])}}, $past(instr_i[15:0])})
		else $error("extended target wrong");
	a_prefix_target: assert property (start && is_imm && cond_take && prefix_valid_i |=>
		next_pc_o == $past(pc_i) + {$past(prefix_hi_i), $past(instr_i[15:0])})
		else $error("prefixed target wrong");
	a_reg_target_sum: assert property (start && is_reg && cond_take |=>
		next_pc_o == $past(pc_i) + $past(offset_source_i)) else $error("register target wrong");
	a_seq_step: assert property (start && !cond_take |=>
		next_pc_o == $past(pc_i) + CBU_SEQ_STEP && !squash_next_o) else $error("step wrong");
	a_lat_one_cycle: assert property (start && !cond_take && !(is_imm && pred_valid_i) |->
		##1 busy_o ##1 done_o && !busy_o) else $error("not-taken latency wrong");
	a_lat_slot_two: assert property (start && cond_take && ins.delay && !pred_valid_i |->
		##1 busy_o[*2] ##1 done_o) else $error("slot latency wrong");
	a_lat_noslot_three: assert property (start && cond_take && !ins.delay && !pred_valid_i |->
		##1 busy_o[*3] ##1 done_o) else $error("no-slot latency wrong");
	a_lat_deep_miss: assert property (start && is_imm && pred_valid_i && pred_taken_i != cond_take
		&& FOOTPRINT_TUNING_PARAM == CBU_FOOTPRINT_DEEP |->
		##1 busy_o[*8] ##1 done_o) else $error("deep mispredict latency wrong");
	a_squash_noslot: assert property (start && cond_take && !ins.delay |=>
		squash_next_o && !slot_o) else $error("successor not squashed");
	a_slot_waits: assert property (done_o && slot_o && !slot_done_i |=>
		state_q == CBU_SLOT) else $error("slot not waited for");
	a_defer_blocks: assert property (defer_o |=> !irq_take_o && !brk_take_o)
		else $error("request passed during deferral");

	c_taken_slot: cover property (start && cond_take && ins.delay ##[1:20] slot_done_i);
	c_taken_noslot: cover property (start && cond_take && !ins.delay);
	c_pred_miss: cover property (start && is_imm && pred_valid_i && pred_taken_i != cond_take);
	c_prefix_used: cover property (start && is_imm && prefix_valid_i);
endmodule : cbu_branch_unit
`default_nettype wire

// >>> cbu_branch_unit_tb.sv
// self-checking testbench for the conditional branch unit
`timescale 1ns/100ps
`default_nettype none
module cbu_branch_unit_tb;
	import cbu_pkg::*;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic issue_i = 1'b0;
	logic prefix_valid_i = 1'b0;
	logic pred_valid_i = 1'b0;
	logic pred_taken_i = 1'b0;
	logic slot_done_i = 1'b0;
	logic irq_req_i = 1'b0;
	logic brk_req_i = 1'b0;
	logic [31:0] instr_i = 32'h0000_0000;
	logic [31:0] pc_i = 32'h0000_0000;
	logic [31:0] compared_source_i = 32'h0000_0000;
	logic [31:0] offset_source_i = 32'h0000_0000;
	logic [15:0] prefix_hi_i = 16'h1234;
	logic busy_o, done_o, taken_o, slot_o, squash_next_o, defer_o, irq_take_o, brk_take_o;
	logic [31:0] next_pc_o;
	logic deep_busy, deep_done;
	logic [31:0] deep_next_pc;
	int n_mismatch = 0;
	int check_count = 0;
	localparam logic [31:0] PC = 32'h0000_1000;
	localparam logic [5:0] RG = CBU_OPC_REG;
	localparam logic [5:0] IM = CBU_OPC_IMM;
	localparam logic [3:0] EQ = CBU_COND_EQ;
	localparam logic [3:0] GE = CBU_COND_GE;
	localparam logic [3:0] GT = CBU_COND_GT;

	always #20 clock_i = ~clock_i;

	cbu_branch_unit #(.FOOTPRINT_TUNING_PARAM(0)) dut (
		.clock_i(clock_i), .srst_i(srst_i), .issue_i(issue_i), .instr_i(instr_i),
		.pc_i(pc_i), .compared_source_i(compared_source_i),
		.offset_source_i(offset_source_i), .prefix_valid_i(prefix_valid_i),
		.prefix_hi_i(prefix_hi_i), .pred_valid_i(pred_valid_i),
		.pred_taken_i(pred_taken_i), .slot_done_i(slot_done_i), .irq_req_i(irq_req_i),
		.brk_req_i(brk_req_i), .busy_o(busy_o), .done_o(done_o), .taken_o(taken_o),
		.slot_o(slot_o), .squash_next_o(squash_next_o), .next_pc_o(next_pc_o),
		.defer_o(defer_o), .irq_take_o(irq_take_o), .brk_take_o(brk_take_o)
	);

	// second copy in the deep pipeline configuration, fed the same stimulus
	cbu_branch_unit #(.FOOTPRINT_TUNING_PARAM(CBU_FOOTPRINT_DEEP)) dut_deep (
		.clock_i(clock_i), .srst_i(srst_i), .issue_i(issue_i), .instr_i(instr_i),
		.pc_i(pc_i), .compared_source_i(compared_source_i),
		.offset_source_i(offset_source_i), .prefix_valid_i(prefix_valid_i),
		.prefix_hi_i(prefix_hi_i), .pred_valid_i(pred_valid_i),
		.pred_taken_i(pred_taken_i), .slot_done_i(slot_done_i), .irq_req_i(irq_req_i),
		.brk_req_i(brk_req_i), .busy_o(deep_busy), .done_o(deep_done), .taken_o(),
		.slot_o(), .squash_next_o(), .next_pc_o(deep_next_pc),
		.defer_o(), .irq_take_o(), .brk_take_o()
	);

	// ****************************************
	// shared tasks
	// ****************************************
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task tick;
		@(posedge clock_i);
		#1;
	endtask : tick

	// hold keeps issue high one more edge while busy, with a different pc, to be refused
	task br(input logic [5:0] opc, input logic d, input logic [3:0] cnd, input logic [15:0] lit,
		input logic [31:0] cmp, input logic [31:0] off, input logic pfx, input logic pv,
		input logic pt, input logic hold, input logic exp_t, input logic [31:0] exp_pc,
		input logic [3:0] exp_lat);
		logic [3:0] lat;
		lat = 4'h0;
		instr_i = {opc, d, cnd, 5'h01, lit};
		pc_i = PC;
		compared_source_i = cmp;
		offset_source_i = off;
		prefix_valid_i = pfx;
		pred_valid_i = pv;
		pred_taken_i = pt;
		issue_i = 1'b1;
		tick();
		issue_i = hold;
		pc_i = 32'h0000_2000;
		while (busy_o === 1'b1 && lat < 4'hF) begin
			lat++;
			tick();
			issue_i = 1'b0;
		end
		check(lat, exp_lat, "latency");
		check(done_o, 1'b1, "done pulse");
		check(taken_o, exp_t, "taken");
		check(next_pc_o, exp_pc, "next pc");
		check(squash_next_o, exp_t & ~d, "squash");
		check(slot_o, d, "slot flag");
		if (d) begin
			check(defer_o, 1'b1, "defer held");
			irq_req_i = 1'b1;
			brk_req_i = 1'b1;
			tick();
			check(irq_take_o, 1'b0, "irq deferred");
			check(brk_take_o, 1'b0, "break deferred");
			slot_done_i = 1'b1;
			tick();
			slot_done_i = 1'b0;
			tick();
			check(defer_o, 1'b0, "defer released");
			tick();
			check(irq_take_o, 1'b1, "irq passed");
			check(brk_take_o, 1'b1, "break passed");
			irq_req_i = 1'b0;
			brk_req_i = 1'b0;
		end
		tick();
	endtask : br

	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	// ****************************************
	// scenarios
	// ****************************************
	task t_zero_imm;
		br(IM, 1'b0, EQ, 16'hFFF0, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0FF0, 4'h3);
		br(IM, 1'b0, EQ, 16'hFFF0, 32'h1, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h1004, 4'h1);
		$display("zero test literal jump done");
	endtask : t_zero_imm

	task t_ge_forms;
		br(RG, 1'b1, GE, 16'h0, 32'h0, 32'h100, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h1100, 4'h2);
		br(RG, 1'b0, GE, 16'h0, 32'h8000_0000, 32'h100, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h1004, 4'h1);
		br(IM, 1'b1, GE, 16'h0040, 32'h7FFF_FFFF, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h1040, 4'h2);
		$display("greater or equal done");
	endtask : t_ge_forms

	task t_gt_reg;
		br(RG, 1'b0, GT, 16'h0, 32'h0, 32'h100, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h1004, 4'h1);
		br(RG, 1'b0, GT, 16'h0, 32'h1, 32'h100, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 32'h1100, 4'h3);
		br(RG, 1'b0, GT, 16'h0, 32'hFFFF_FFFF, 32'h100, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 32'h1004, 4'h1);
		$display("positive test reg jump done");
	endtask : t_gt_reg

	task t_prefix;
		br(IM, 1'b0, EQ, 16'h8000, 32'h0, 32'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 32'h1234_9000, 4'h3);
		br(IM, 1'b0, EQ, 16'h8000, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'hFFFF_9000, 4'h3);
		br(RG, 1'b0, GE, 16'h0, 32'h0, 32'h100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 32'h1100, 4'h3);
		$display("prefix override done");
	endtask : t_prefix

	task t_predict;
		br(IM, 1'b0, GT, 16'h0010, 32'h5, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 32'h1010, 4'h1);
		br(IM, 1'b0, GT, 16'h0010, 32'h0, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 32'h1004, 4'h3);
		$display("prediction done");
	endtask : t_predict

	// illegal encodings must leave the unit idle
	task t_refuse;
		instr_i = {RG, 1'b0, EQ, 5'h01, 16'h0};
		issue_i = 1'b1;
		tick();
		instr_i = {IM, 1'b0, 4'h3, 5'h01, 16'h0};
		tick();
		issue_i = 1'b0;
		check(busy_o, 1'b0, "illegal ignored");
		tick();
		check(done_o, 1'b0, "no completion");
		$display("refusal done");
	endtask : t_refuse

	// mispredicted literal branch on the deep copy; the idle gap lets it drain first
	task t_deep_miss;
		logic [3:0] n;
		n = 4'h0;
		repeat (10) tick();
		instr_i = {IM, 1'b0, GT, 5'h01, 16'h0010};
		pc_i = PC;
		compared_source_i = 32'h0000_0000;
		prefix_valid_i = 1'b0;
		pred_valid_i = 1'b1;
		pred_taken_i = 1'b1;
		issue_i = 1'b1;
		tick();
		issue_i = 1'b0;
		while (deep_busy === 1'b1 && n < 4'hF) begin
			n++;
			tick();
		end
		check(n, CBU_LAT_MISPRED_DEEP, "deep mispredict latency");
		check(deep_done, 1'b1, "deep done pulse");
		check(deep_next_pc, PC + CBU_SEQ_STEP, "deep next pc");
		tick();
		$display("deep pipeline mispredict done");
	endtask : t_deep_miss

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(posedge clock_i);
		#1;
		srst_i = 1'b0;
		check(busy_o, 1'b0, "busy after reset");
		check(next_pc_o, 32'h0, "pc after reset");
		t_zero_imm();
		t_ge_forms();
		t_gt_reg();
		t_prefix();
		t_predict();
		t_refuse();
		t_deep_miss();
		wrap_up();
	end

	// the whole sequence needs well under a few hundred cycles
	initial begin
		repeat (3000) @(posedge clock_i);
		n_mismatch++;
		$display("MISMATCH %0t watchdog expired", $time);
		wrap_up();
	end
endmodule : cbu_branch_unit_tb
`default_nettype wire
